// ### rtl/dsm_consts.vh
`ifndef DSM_CONSTS_VH
`define DSM_CONSTS_VH
// register byte offsets
`define DSM_OFF_CTRL 12'h000
`define DSM_OFF_ZC 12'h004
`define DSM_OFF_OC 12'h008
`define DSM_OFF_ARR_A 12'h00c
`define DSM_OFF_ARR_B 12'h010
`define DSM_OFF_RT_MIN 12'h014
`define DSM_OFF_WIN 12'h018
`define DSM_OFF_TEMP 12'h01c
`define DSM_OFF_FREQ 12'h020
`define DSM_OFF_SLP_DLY 12'h024
`define DSM_OFF_OL 12'h028
`define DSM_OFF_STAT 12'h02c
`define DSM_OFF_REMAIN 12'h030
// ctrl field positions
`define DSM_CTRL_RT_EN 0
`define DSM_CTRL_RT_SRC_LO 1
`define DSM_CTRL_FAN 3
`define DSM_CTRL_OL_EN 4
`define DSM_CTRL_SLP_LOOP 5
`define DSM_CTRL_RLY_LO 6
`define DSM_CTRL_FDO_LO 9
`define DSM_CTRL_RST 32'h0000_0010
// status bit of overload fault (write one to clear)
`define DSM_STAT_OL 8
// reset values, 0.1 % / 0.01 s / 0.01 V / degC / 0.01 Hz / 0.1 s units
`define DSM_ZC_LVL_RST 16'h0032
`define DSM_ZC_DLY_RST 16'h000a
`define DSM_OC_THR_RST 16'h07d0
`define DSM_OC_DLY_RST 16'h0000
`define DSM_ARR_LVL_RST 16'h03e8
`define DSM_ARR_W_RST 16'h0000
`define DSM_WIN_LO_RST 16'h0136
`define DSM_WIN_HI_RST 16'h02a8
`define DSM_TEMP_RST 16'h004b
`define DSM_GAIN_RST 16'h0064
`define DSM_PREW_RST 16'h0050
// setting limits
`define DSM_CUR_MAX 16'h0bb8
`define DSM_DLY_MAX 16'hea60
`define DSM_RT_MAX 16'hfde8
`define DSM_VOLT_MAX 16'h03e8
`define DSM_TEMP_MAX 16'h0064
`define DSM_GAIN_MIN 16'h0014
`define DSM_GAIN_MAX 16'h03e8
`define DSM_PREW_MIN 16'h0032
`define DSM_PREW_MAX 16'h0064
`define DSM_FAN_TEMP 8'h28
// analog full scale in per mille
`define DSM_AI_FS 10'h3e8
// timing: 10 ms sampling tick, 0.1 s and 0.1 min units in ticks
`define DSM_CLK_KHZ 250000
`define DSM_TICK_MS 10
`define DSM_SLOW_TICKS 8'h0a
`define DSM_RT_UNIT_TICKS 12'h258
// overload curve: knee current and trip integral in ticks
`define DSM_OL_BASE 15'h05cd
`define DSM_OL_K 13'h1bfc
`define DSM_PCT 7'h64
`endif

// ### rtl/dsm_monitor.v
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "dsm_consts.vh"

module dsm_monitor #(
  parameter TICK_CYCLES = `DSM_TICK_MS * `DSM_CLK_KHZ
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire drive_running,
  input wire run_cmd,
  input wire freq_from_pid,
  input wire [11:0] out_current,
  input wire [9:0] analog_input_one,
  input wire [9:0] analog_input_two,
  input wire [9:0] analog_input_three,
  input wire [7:0] heatsink_temp,
  input wire [15:0] freq_ref,
  input wire [15:0] max_freq,
  output reg relay_output_one,
  output reg fast_digital_output,
  output reg fan_on,
  output reg runtime_stop,
  output reg sleep_active,
  output reg pid_run_enable,
  output reg overload_fault
);

  localparam ST_AWAKE = 2'b01;
  localparam ST_SLEEP = 2'b10;

  function [15:0] clampu;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (v < lo) begin
        clampu = lo;
      end else if (v > hi) begin
        clampu = hi;
      end else begin
        clampu = v;
      end
    end
  endfunction

  reg [31:0] ctrl_reg;
  reg [15:0] zc_lvl_reg;
  reg [15:0] zc_dly_reg;
  reg [15:0] oc_thr_reg;
  reg [15:0] oc_dly_reg;
  reg [15:0] arr_lvl_reg [0:1];
  reg [15:0] arr_w_reg [0:1];
  reg [15:0] rt_min_reg;
  reg [15:0] win_lo_reg;
  reg [15:0] win_hi_reg;
  reg [15:0] temp_thr_reg;
  reg [15:0] wake_f_reg;
  reg [15:0] sleep_f_reg;
  reg [15:0] wake_dly_reg;
  reg [15:0] sleep_dly_reg;
  reg [15:0] gain_reg;
  reg [15:0] prew_reg;

  wire acc_w = psel & penable & pwrite;
  wire setup = psel & ~penable;
  reg mapped;
  always @* begin
    case (paddr)
      `DSM_OFF_CTRL, `DSM_OFF_ZC, `DSM_OFF_OC, `DSM_OFF_ARR_A,
      `DSM_OFF_ARR_B, `DSM_OFF_RT_MIN, `DSM_OFF_WIN, `DSM_OFF_TEMP,
      `DSM_OFF_FREQ, `DSM_OFF_SLP_DLY, `DSM_OFF_OL, `DSM_OFF_STAT,
      `DSM_OFF_REMAIN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // zero-wait slave; data staged during setup
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // sampling tick and slower 0.1 s tick
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg [7:0] slow_cnt_reg;
  reg slow_reg;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
      slow_cnt_reg <= 8'h0;
      slow_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      slow_reg <= 1'b0;
      if (tick_cnt_reg >= TICK_CYCLES - 1) begin
        tick_cnt_reg <= 32'h0;
        tick_reg <= 1'b1;
        if (slow_cnt_reg >= `DSM_SLOW_TICKS - 8'h01) begin
          slow_cnt_reg <= 8'h0;
          slow_reg <= 1'b1;
        end else begin
          slow_cnt_reg <= slow_cnt_reg + 8'h01;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
    end
  end

  // samples, refreshed once per tick
  reg [11:0] cur_s;
  reg [9:0] ai1_s;
  reg [9:0] ai2_s;
  reg [9:0] ai3_s;
  reg [7:0] temp_s;
  reg [15:0] fref_s;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cur_s <= 12'h0;
      ai1_s <= 10'h0;
      ai2_s <= 10'h0;
      ai3_s <= 10'h0;
      temp_s <= 8'h0;
      fref_s <= 16'h0;
    end else if (tick_reg) begin
      cur_s <= out_current;
      ai1_s <= analog_input_one;
      ai2_s <= analog_input_two;
      ai3_s <= analog_input_three;
      temp_s <= heatsink_temp;
      fref_s <= freq_ref;
    end
  end

  // effective confined settings
  wire [15:0] win_hi_eff = clampu(win_hi_reg, 16'h0, `DSM_VOLT_MAX);
  wire [15:0] win_lo_eff = clampu(win_lo_reg, 16'h0, win_hi_eff);
  wire [15:0] wake_eff = clampu(wake_f_reg, 16'h0, max_freq);
  wire [15:0] sleep_eff = clampu(sleep_f_reg, 16'h0, wake_eff);
  wire slp_en = (wake_f_reg != 16'h0) | (sleep_f_reg != 16'h0);

  // comparators
  wire [15:0] cur16 = {4'h0, cur_s};
  wire zc_cond = cur16 <= zc_lvl_reg;
  wire oc_cond = (oc_thr_reg != 16'h0) & (cur16 >= oc_thr_reg);
  wire [1:0] arr_hit;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_arr
      wire [16:0] hi = {1'b0, arr_lvl_reg[g]} + {1'b0, arr_w_reg[g]};
      wire [16:0] lo_sum = {1'b0, cur16} + {1'b0, arr_w_reg[g]};
      assign arr_hit[g] = ({1'b0, cur16} <= hi) &
        (lo_sum >= {1'b0, arr_lvl_reg[g]});
    end
  endgenerate
  wire win_out = ({6'h0, ai1_s} > win_hi_eff) |
    ({6'h0, ai1_s} < win_lo_eff);
  wire overheat = {8'h0, temp_s} >= temp_thr_reg;

  // delayed detectors: 0 zero, 1 over-current, 2 sleep entry, 3 wake
  reg [1:0] st_reg;
  wire [3:0] det_cond;
  wire [3:0] det_tick = {slow_reg, slow_reg, tick_reg, tick_reg};
  wire [63:0] det_dly = {wake_dly_reg, sleep_dly_reg, oc_dly_reg, zc_dly_reg};
  wire [3:0] det_out;
  assign det_cond[0] = zc_cond;
  assign det_cond[1] = oc_cond;
  assign det_cond[2] = slp_en & (st_reg == ST_AWAKE) & drive_running &
    (fref_s <= sleep_eff);
  assign det_cond[3] = (st_reg == ST_SLEEP) & run_cmd &
    (fref_s >= wake_eff);
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_det
      reg [16:0] cnt_reg;
      always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_reg <= 17'h0;
        end else if (!det_cond[g]) begin
          cnt_reg <= 17'h0;
        end else if (det_tick[g] && cnt_reg <= {1'b0, det_dly[g*16 +: 16]}) begin
          cnt_reg <= cnt_reg + 17'h1;
        end
      end
      // strictly longer than the delay
      assign det_out[g] = det_cond[g] &
        (cnt_reg > {1'b0, det_dly[g*16 +: 16]});
    end
  endgenerate

  // sleep and wake
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= ST_AWAKE;
    end else begin
      case (st_reg)
        ST_AWAKE: begin
          if (det_out[2]) begin
            st_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!slp_en || !run_cmd || det_out[3]) begin
            st_reg <= ST_AWAKE;
          end
        end
        default: st_reg <= ST_AWAKE;
      endcase
    end
  end

  // run-time limit
  reg run_d_reg;
  reg [11:0] rt_sub_reg;
  reg [15:0] rt_el_reg;
  reg rt_done_reg;
  reg [9:0] ai_sel;
  reg [25:0] rt_prod;
  reg [25:0] rt_quo;
  reg [15:0] rt_lim;
  always @* begin
    case (ctrl_reg[`DSM_CTRL_RT_SRC_LO +: 2])
      2'h1: ai_sel = ai1_s;
      2'h2: ai_sel = ai2_s;
      2'h3: ai_sel = ai3_s;
      default: ai_sel = `DSM_AI_FS;
    endcase
    if (ai_sel > `DSM_AI_FS) begin
      ai_sel = `DSM_AI_FS;
    end
    rt_prod = rt_min_reg * ai_sel;
    rt_quo = rt_prod / `DSM_AI_FS;
    // quotient never exceeds the stored minutes, so the top bits are zero
    rt_lim = rt_quo[15:0];
  end
  wire rt_en = ctrl_reg[`DSM_CTRL_RT_EN];
  wire [15:0] rt_remain = (rt_el_reg >= rt_lim) ? 16'h0 : rt_lim - rt_el_reg;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_d_reg <= 1'b0;
      rt_sub_reg <= 12'h0;
      rt_el_reg <= 16'h0;
      rt_done_reg <= 1'b0;
    end else begin
      run_d_reg <= drive_running;
      if (drive_running && !run_d_reg) begin
        rt_sub_reg <= 12'h0;
        rt_el_reg <= 16'h0;
        rt_done_reg <= 1'b0;
      end else begin
        if (drive_running && tick_reg && !rt_done_reg) begin
          if (rt_sub_reg >= `DSM_RT_UNIT_TICKS - 12'h001) begin
            rt_sub_reg <= 12'h0;
            rt_el_reg <= rt_el_reg + 16'h1;
          end else begin
            rt_sub_reg <= rt_sub_reg + 12'h001;
          end
        end
        if (rt_en && drive_running && rt_el_reg >= rt_lim) begin
          rt_done_reg <= 1'b1;
        end
      end
    end
  end

  // inverse-time overload: heat grows with cur^2 above knee^2
  wire [24:0] ol_lvl_p = `DSM_OL_BASE * gain_reg[9:0];
  wire [24:0] ol_lvl_q = ol_lvl_p / `DSM_PCT;
  wire [14:0] ol_lvl = ol_lvl_q[14:0];
  wire [29:0] lvl_sq = ol_lvl * ol_lvl;
  wire [29:0] cur_sq = cur_s * cur_s;
  wire [42:0] ol_lim = lvl_sq * `DSM_OL_K;
  reg [42:0] ol_acc_reg;
  reg ol_prew_reg;
  wire ol_en = ctrl_reg[`DSM_CTRL_OL_EN];
  wire [49:0] acc_pct = ol_acc_reg * `DSM_PCT;
  wire [49:0] lim_pct = ol_lim * prew_reg[6:0];
  wire ol_clr = acc_w & (paddr == `DSM_OFF_STAT) & pwdata[`DSM_STAT_OL];
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ol_acc_reg <= 43'h0;
      ol_prew_reg <= 1'b0;
      overload_fault <= 1'b0;
    end else if (!ol_en) begin
      ol_acc_reg <= 43'h0;
      ol_prew_reg <= 1'b0;
      overload_fault <= 1'b0;
    end else begin
      if (tick_reg) begin
        if (cur_sq > lvl_sq) begin
          ol_acc_reg <= ol_acc_reg + {13'h0, cur_sq - lvl_sq};
        end else if (ol_acc_reg > {13'h0, lvl_sq - cur_sq}) begin
          ol_acc_reg <= ol_acc_reg - {13'h0, lvl_sq - cur_sq};
        end else begin
          ol_acc_reg <= 43'h0;
        end
      end
      ol_prew_reg <= acc_pct > lim_pct;
      // set wins over a clear in the same cycle
      if (ol_acc_reg >= ol_lim) begin
        overload_fault <= 1'b1;
      end else if (ol_clr) begin
        overload_fault <= 1'b0;
      end
    end
  end

  // output terminals
  wire [4:0] rly_src = {rt_done_reg, arr_hit, det_out[1], det_out[0]};
  wire [2:0] fdo_src = {ol_prew_reg, overheat, win_out};
  wire [2:0] rly_sel = ctrl_reg[`DSM_CTRL_RLY_LO +: 3];
  wire [1:0] fdo_sel = ctrl_reg[`DSM_CTRL_FDO_LO +: 2];
  wire [10:0] stat = {st_reg == ST_SLEEP, fan_on, overload_fault,
    fdo_src, rly_src};
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      relay_output_one <= 1'b0;
      fast_digital_output <= 1'b0;
      fan_on <= 1'b0;
      runtime_stop <= 1'b0;
      sleep_active <= 1'b0;
      pid_run_enable <= 1'b1;
    end else begin
      relay_output_one <= (rly_sel < 3'h5) & rly_src[rly_sel];
      fast_digital_output <= (fdo_sel < 2'h3) & fdo_src[fdo_sel];
      if (ctrl_reg[`DSM_CTRL_FAN]) begin
        fan_on <= 1'b1;
      end else begin
        fan_on <= drive_running | (temp_s > `DSM_FAN_TEMP);
      end
      runtime_stop <= rt_done_reg;
      sleep_active <= st_reg == ST_SLEEP;
      pid_run_enable <= !(st_reg == ST_SLEEP && freq_from_pid &&
        !ctrl_reg[`DSM_CTRL_SLP_LOOP]);
    end
  end

  // register writes, values confined to their ranges except the sleep/wake frequencies and delays, stored as written
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `DSM_CTRL_RST;
      zc_lvl_reg <= `DSM_ZC_LVL_RST;
      zc_dly_reg <= `DSM_ZC_DLY_RST;
      oc_thr_reg <= `DSM_OC_THR_RST;
      oc_dly_reg <= `DSM_OC_DLY_RST;
      arr_lvl_reg[0] <= `DSM_ARR_LVL_RST;
      arr_w_reg[0] <= `DSM_ARR_W_RST;
      arr_lvl_reg[1] <= `DSM_ARR_LVL_RST;
      arr_w_reg[1] <= `DSM_ARR_W_RST;
      rt_min_reg <= 16'h0;
      win_lo_reg <= `DSM_WIN_LO_RST;
      win_hi_reg <= `DSM_WIN_HI_RST;
      temp_thr_reg <= `DSM_TEMP_RST;
      wake_f_reg <= 16'h0;
      sleep_f_reg <= 16'h0;
      wake_dly_reg <= 16'h0;
      sleep_dly_reg <= 16'h0;
      gain_reg <= `DSM_GAIN_RST;
      prew_reg <= `DSM_PREW_RST;
    end else if (acc_w) begin
      case (paddr)
        `DSM_OFF_CTRL: ctrl_reg <= {20'h0, pwdata[11:0]};
        `DSM_OFF_ZC: begin
          zc_lvl_reg <= clampu(pwdata[15:0], 16'h0, `DSM_CUR_MAX);
          zc_dly_reg <= clampu(pwdata[31:16], 16'h0, `DSM_DLY_MAX);
        end
        `DSM_OFF_OC: begin
          oc_thr_reg <= clampu(pwdata[15:0], 16'h0, `DSM_CUR_MAX);
          oc_dly_reg <= clampu(pwdata[31:16], 16'h0, `DSM_DLY_MAX);
        end
        `DSM_OFF_ARR_A: begin
          arr_lvl_reg[0] <= clampu(pwdata[15:0], 16'h0, `DSM_CUR_MAX);
          arr_w_reg[0] <= clampu(pwdata[31:16], 16'h0, `DSM_CUR_MAX);
        end
        `DSM_OFF_ARR_B: begin
          arr_lvl_reg[1] <= clampu(pwdata[15:0], 16'h0, `DSM_CUR_MAX);
          arr_w_reg[1] <= clampu(pwdata[31:16], 16'h0, `DSM_CUR_MAX);
        end
        `DSM_OFF_RT_MIN: rt_min_reg <= clampu(pwdata[15:0], 16'h0, `DSM_RT_MAX);
        `DSM_OFF_WIN: begin
          win_lo_reg <= clampu(pwdata[15:0], 16'h0, `DSM_VOLT_MAX);
          win_hi_reg <= clampu(pwdata[31:16], 16'h0, `DSM_VOLT_MAX);
        end
        `DSM_OFF_TEMP: temp_thr_reg <= clampu(pwdata[15:0], 16'h0, `DSM_TEMP_MAX);
        `DSM_OFF_FREQ: begin
          wake_f_reg <= pwdata[15:0];
          sleep_f_reg <= pwdata[31:16];
        end
        `DSM_OFF_SLP_DLY: begin
          wake_dly_reg <= pwdata[15:0];
          sleep_dly_reg <= pwdata[31:16];
        end
        `DSM_OFF_OL: begin
          gain_reg <= clampu(pwdata[15:0], `DSM_GAIN_MIN, `DSM_GAIN_MAX);
          prew_reg <= clampu(pwdata[31:16], `DSM_PREW_MIN, `DSM_PREW_MAX);
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // read data staged in the setup phase
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (setup) begin
      case (paddr)
        `DSM_OFF_CTRL: prdata <= ctrl_reg;
        `DSM_OFF_ZC: prdata <= {zc_dly_reg, zc_lvl_reg};
        `DSM_OFF_OC: prdata <= {oc_dly_reg, oc_thr_reg};
        `DSM_OFF_ARR_A: prdata <= {arr_w_reg[0], arr_lvl_reg[0]};
        `DSM_OFF_ARR_B: prdata <= {arr_w_reg[1], arr_lvl_reg[1]};
        `DSM_OFF_RT_MIN: prdata <= {16'h0, rt_min_reg};
        `DSM_OFF_WIN: prdata <= {win_hi_reg, win_lo_reg};
        `DSM_OFF_TEMP: prdata <= {16'h0, temp_thr_reg};
        `DSM_OFF_FREQ: prdata <= {sleep_f_reg, wake_f_reg};
        `DSM_OFF_SLP_DLY: prdata <= {sleep_dly_reg, wake_dly_reg};
        `DSM_OFF_OL: prdata <= {prew_reg, gain_reg};
        `DSM_OFF_STAT: prdata <= {21'h0, stat};
        `DSM_OFF_REMAIN: prdata <= {16'h0, rt_remain};
        default: prdata <= 32'h0;
      endcase
    end
  end

endmodule

// ### tb/drive_supervision_monitors_bench.sv
`timescale 1ns/10ps
`include "dsm_consts.vh"
module drive_supervision_monitors_bench;
  localparam int TK = 20;
  logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, run_req = 0;
  logic run_cmd = 0, pid_sel = 0, pready, pslverr, rde, drive_running;
  logic relay, fdo, fan_on, rt_stop, slp, pid_en, ol_fault;
  logic [11:0] paddr = 0, cur_req = 0, out_current;
  logic [31:0] pwdata = 0, prdata, rdv;
  logic [9:0] an_one = 10'd500;
  logic [9:0] an_two = 10'h0, an_three = 10'h0;
  logic [7:0] temp = 0;
  logic [15:0] freq_ref = 0;
  int mismatches = 0, cmp_count = 0, cyc = 0, lv, wd;
  logic [11:0] ra [0:9] = '{`DSM_OFF_CTRL, `DSM_OFF_ZC, `DSM_OFF_OC, `DSM_OFF_ARR_A,
    `DSM_OFF_ARR_B, `DSM_OFF_RT_MIN, `DSM_OFF_WIN, `DSM_OFF_TEMP, `DSM_OFF_OL, 12'h040};
  logic [31:0] rv [0:9] = '{`DSM_CTRL_RST, {`DSM_ZC_DLY_RST, `DSM_ZC_LVL_RST},
    {`DSM_OC_DLY_RST, `DSM_OC_THR_RST}, {`DSM_ARR_W_RST, `DSM_ARR_LVL_RST},
    {`DSM_ARR_W_RST, `DSM_ARR_LVL_RST}, 32'h0, {`DSM_WIN_HI_RST, `DSM_WIN_LO_RST},
    {16'h0, `DSM_TEMP_RST}, {`DSM_PREW_RST, `DSM_GAIN_RST}, 32'h0};
  logic [9:0] wv [0:3] = '{10'd310, 10'd309, 10'd680, 10'd681};
  always #2 clk_sys = ~clk_sys;
  dsm_plant plant_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .run_req(run_req),
    .cur_req(cur_req), .runtime_stop(rt_stop), .drive_running(drive_running),
    .out_current(out_current));
  dsm_monitor #(.TICK_CYCLES(TK)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_running(drive_running), .run_cmd(run_cmd),
    .freq_from_pid(pid_sel), .out_current(out_current), .analog_input_one(an_one),
    .analog_input_two(an_two), .analog_input_three(an_three), .heatsink_temp(temp),
    .freq_ref(freq_ref), .max_freq(16'd5000), .relay_output_one(relay),
    .fast_digital_output(fdo), .fan_on(fan_on), .runtime_stop(rt_stop),
    .sleep_active(slp), .pid_run_enable(pid_en), .overload_fault(ol_fault));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // full-scale analog input stands for the stored minutes
  function automatic logic [31:0] rt_exp(input int mins, input int ai);
    return mins * (ai > 1000 ? 1000 : ai) / 1000;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // waits whole ticks, then settles on the falling edge before looking
  task automatic tk(input int n);
    repeat (n * TK) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic put(input logic [11:0] c);
    @(posedge clk_sys);
    cur_req <= c;
  endtask
  task automatic restart;
    @(posedge clk_sys);
    run_req <= 1'b0;
    tk(1);
    @(posedge clk_sys);
    run_req <= 1'b1;
    tk(2);
  endtask
  initial begin
    lv = $urandom(24423);
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      apb(0, ra[i], 0);
      chk("reset value", rdv, rv[i]);
      chk("slave error", rde, i == 9);
    end
    apb(1, `DSM_OFF_ZC, 32'hffff_ffff);
    apb(0, `DSM_OFF_ZC, 0);
    chk("zero clamp", rdv, {`DSM_DLY_MAX, `DSM_CUR_MAX});
    apb(1, `DSM_OFF_CTRL, 0);
    @(posedge clk_sys);
    run_req <= 1'b1;
    run_cmd <= 1'b1;
    put(12'd3000);
    lv = $urandom_range(2999, 100);
    apb(1, `DSM_OFF_ZC, {16'd2, lv[15:0]});
    tk(2);
    chk("zero idle", relay, 0);
    put(lv[11:0]);
    tk(2);
    chk("zero early", relay, 0);
    tk(3);
    chk("zero hit", relay, 1);
    put(lv[11:0] + 12'd1);
    tk(2);
    chk("zero drop", relay, 0);
    lv = $urandom_range(3000, 1);
    apb(1, `DSM_OFF_CTRL, 32'h40);
    apb(1, `DSM_OFF_OC, {16'd0, lv[15:0]});
    put(lv[11:0] - 12'd1);
    tk(3);
    chk("oc below", relay, 0);
    put(lv[11:0]);
    tk(3);
    chk("oc at", relay, 1);
    apb(1, `DSM_OFF_OC, 0);
    tk(2);
    chk("oc off", relay, 0);
    for (int k = 0; k < 2; k++) begin
      lv = $urandom_range(2800, 200);
      wd = $urandom_range(100, 0);
      apb(1, `DSM_OFF_CTRL, (k + 2) << 6);
      apb(1, k ? `DSM_OFF_ARR_B : `DSM_OFF_ARR_A, {wd[15:0], lv[15:0]});
      put(lv[11:0] + wd[11:0]);
      tk(2);
      chk("arrival in", relay, 1);
      put(lv[11:0] - wd[11:0] - 12'd1);
      tk(2);
      chk("arrival out", relay, 0);
    end
    apb(1, `DSM_OFF_CTRL, 0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      an_one <= wv[i];
      tk(2);
      chk("window", fdo, wv[i] < `DSM_WIN_LO_RST || wv[i] > `DSM_WIN_HI_RST);
    end
    apb(1, `DSM_OFF_CTRL, 32'h200);
    for (int t = 74; t < 76; t++) begin
      @(posedge clk_sys);
      temp <= t;
      tk(2);
      chk("overheat", fdo, t >= `DSM_TEMP_RST);
    end
    @(posedge clk_sys);
    run_req <= 1'b0;
    for (int t = 40; t < 42; t++) begin
      @(posedge clk_sys);
      temp <= t;
      tk(2);
      chk("fan idle", fan_on, t > `DSM_FAN_TEMP);
    end
    apb(1, `DSM_OFF_CTRL, 32'h8);
    @(posedge clk_sys);
    temp <= 8'd0;
    tk(2);
    chk("fan always", fan_on, 1);
    apb(1, `DSM_OFF_CTRL, 0);
    apb(1, `DSM_OFF_FREQ, 32'h01f4_03e8);
    apb(1, `DSM_OFF_SLP_DLY, 32'h0001_0001);
    @(posedge clk_sys);
    run_req <= 1'b1;
    pid_sel <= 1'b1;
    freq_ref <= 16'd500;
    tk(10);
    chk("sleep early", slp, 0);
    tk(11);
    chk("asleep", slp, 1);
    chk("loop halted", pid_en, 0);
    @(posedge clk_sys);
    freq_ref <= 16'd1000;
    tk(22);
    chk("awake", slp, 0);
    chk("loop on", pid_en, 1);
    apb(1, `DSM_OFF_FREQ, 0);
    @(posedge clk_sys);
    freq_ref <= 16'd0;
    tk(22);
    chk("sleep off", slp, 0);
    apb(1, `DSM_OFF_OL, 32'h0050_0014);
    apb(1, `DSM_OFF_CTRL, 32'h410);
    put(12'd3000);
    tk(50);
    chk("prewarn early", fdo, 0);
    chk("ol early", ol_fault, 0);
    tk(12);
    chk("prewarn", fdo, 1);
    tk(13);
    chk("ol trip", ol_fault, 1);
    put(12'd0);
    tk(3);
    chk("ol sticky", ol_fault, 1);
    // heat still above the trip level, so the clear must lose
    apb(1, `DSM_OFF_STAT, 32'h100);
    tk(1);
    chk("ol set wins", ol_fault, 1);
    apb(1, `DSM_OFF_CTRL, 32'h400);
    put(12'd3000);
    tk(80);
    chk("ol off", ol_fault, 0);
    apb(1, `DSM_OFF_RT_MIN, 32'h1);
    apb(1, `DSM_OFF_CTRL, 32'h101);
    restart;
    apb(0, `DSM_OFF_REMAIN, 0);
    chk("remaining", rdv, 1);
    tk(580);
    chk("limit early", rt_stop, 0);
    tk(24);
    chk("limit stop", rt_stop, 1);
    chk("limit relay", relay, 1);
    chk("drive stopped", drive_running, 0);
    restart;
    chk("restart", rt_stop, 0);
    // low above high: low is held at high, so only the high level counts
    apb(1, `DSM_OFF_WIN, 32'h01f4_02bc);
    apb(1, `DSM_OFF_CTRL, 0);
    @(posedge clk_sys);
    an_one <= 10'd500;
    tk(2);
    chk("window confined", fdo, 0);
    apb(1, `DSM_OFF_RT_MIN, 32'h64);
    for (int s = 1; s < 4; s++) begin
      wd = $urandom_range(1023, 0);
      @(posedge clk_sys);
      if (s == 1) begin
        an_one <= wd[9:0];
      end else if (s == 2) begin
        an_two <= wd[9:0];
      end else begin
        an_three <= wd[9:0];
      end
      apb(1, `DSM_OFF_CTRL, 32'h100 | (s << 1));
      tk(2);
      apb(0, `DSM_OFF_REMAIN, 0);
      chk("limit source", rdv, rt_exp(100, wd));
    end
    final_report;
  end
endmodule
bind dsm_monitor dsm_monitor_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive_running(drive_running),
  .relay_output_one(relay_output_one), .fan_on(fan_on), .runtime_stop(runtime_stop),
  .sleep_active(sleep_active), .pid_run_enable(pid_run_enable),
  .overload_fault(overload_fault));

// ### tb/dsm_monitor_asserts.sv
`timescale 1ns/10ps
module dsm_monitor_asserts #(
  parameter TICK_CYCLES = 20
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire drive_running,
  input wire relay_output_one,
  input wire fan_on,
  input wire runtime_stop,
  input wire sleep_active,
  input wire pid_run_enable,
  input wire overload_fault
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence apb_access;
    psel && penable;
  endsequence
  sequence apb_released;
    apb_access ##1 !psel;
  endsequence
  logic [7:0] run_len;
  logic [7:0] wr_age;
  // fan_on follows drive_running and the fault clear follows the write within a cycle; both windows still allow a full tick
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_len <= 8'h00;
      wr_age <= 8'hff;
    end else begin
      run_len <= !drive_running ? 8'h00 : (run_len == 8'hff ? run_len : run_len + 8'h01);
      wr_age <= (psel && penable && pwrite) ? 8'h00 : (wr_age == 8'hff ? wr_age : wr_age + 8'h01);
    end
  end
  reset_outputs_a: assert property ($fell(sys_rst) |-> !relay_output_one && !fan_on
    && !runtime_stop && !overload_fault && pid_run_enable) else $error("outputs wrong after reset");
  ready_always_a: assert property (pready) else $error("pready low");
  error_in_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  rdata_stands_a: assert property (apb_released |-> $stable(prdata)) else $error("prdata moved");
  fan_while_running_a: assert property (run_len > TICK_CYCLES + 4 && !sleep_active |-> fan_on)
    else $error("fan off while running");
  fault_sticky_a: assert property ($fell(overload_fault) |-> wr_age <= TICK_CYCLES + 4)
    else $error("overload fault dropped by itself");
  limit_while_run_a: assert property ($rose(runtime_stop) |-> $past(drive_running))
    else $error("run-time limit while stopped");
  limit_restart_a: assert property ($rose(drive_running) |-> ##[1:120] !runtime_stop)
    else $error("limit not cleared on start");
endmodule

// ### tb/dsm_plant.sv
`timescale 1ns/10ps
module dsm_plant (
  input wire clk_sys,
  input wire sys_rst,
  input wire run_req,
  input wire [11:0] cur_req,
  input wire runtime_stop,
  output logic drive_running,
  output wire [11:0] out_current
);
  logic req_d;
  logic stop_d;
  // a stopped motor carries no current, whatever the bench asks for
  assign out_current = drive_running ? cur_req : 12'h000;
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      drive_running <= 1'b0;
      req_d <= 1'b0;
      stop_d <= 1'b0;
    end else begin
      req_d <= run_req;
      stop_d <= runtime_stop;
      if (!run_req || (runtime_stop && !stop_d)) begin
        drive_running <= 1'b0;
      end else if (!req_d) begin
        drive_running <= 1'b1;
      end
    end
  end
endmodule
